// File: rtl/serial_control_i2c_target.v
`timescale 1ns/1ps
`include "serial_control_i2c_target_regs.vh"

module serial_control_i2c_target #(
	parameter [15:0] SCL_QUARTER = `SCL_QUARTER_CYC
) (
	input  wire       ref_clk,
	input  wire       reset,
	input  wire [2:0] address_strap_pin,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        scl_out_ff,
	output reg        scl_oe_n_ff,
	output reg        sda_out_ff,
	output reg        sda_oe_n_ff,
	output reg  [6:0] own_addr_ff,
	input  wire       remote_req,
	input  wire       remote_we,
	input  wire [7:0] remote_addr,
	input  wire [7:0] remote_wdata,
	output reg        remote_ack_ff,
	output reg  [7:0] remote_rdata_ff,
	input  wire       px_req,
	input  wire [6:0] px_target,
	input  wire [7:0] px_offset,
	input  wire [7:0] px_data,
	output reg        px_busy_ff,
	output reg        px_done_ff,
	output reg        px_lost_ff
);

	localparam [2:0] T_IDLE = 3'h0;
	localparam [2:0] T_ADDR = 3'h1;
	localparam [2:0] T_AACK = 3'h2;
	localparam [2:0] T_WR   = 3'h3;
	localparam [2:0] T_WACK = 3'h4;
	localparam [2:0] T_RD   = 3'h5;
	localparam [2:0] T_RACK = 3'h6;

	localparam [2:0] M_IDLE  = 3'h0;
	localparam [2:0] M_WAIT  = 3'h1;
	localparam [2:0] M_START = 3'h2;
	localparam [2:0] M_BITS  = 3'h3;
	localparam [2:0] M_STOP  = 3'h4;

	// Strap level to bus address; eight levels give eight devices per bus.
	function [6:0] strap_to_addr;
		input [2:0] lvl;
		begin
			case (lvl)
				3'h0: strap_to_addr = `TGT_ADDR_0;
				3'h1: strap_to_addr = `TGT_ADDR_1;
				3'h2: strap_to_addr = `TGT_ADDR_2;
				3'h3: strap_to_addr = `TGT_ADDR_3;
				3'h4: strap_to_addr = `TGT_ADDR_4;
				3'h5: strap_to_addr = `TGT_ADDR_5;
				3'h6: strap_to_addr = `TGT_ADDR_6;
				default: strap_to_addr = `TGT_ADDR_7;
			endcase
		end
	endfunction

	// ****************************************************************
	// Pin sampling and bus condition detection.
	// ****************************************************************
	reg [2:0] scl_sync_ff;
	reg [2:0] sda_sync_ff;
	reg       scl_f_ff;
	reg       sda_f_ff;
	reg       scl_prev_ff;
	reg       sda_prev_ff;
	reg       strap_done_ff;
	reg       bus_busy_ff;
	wire      scl_rise = scl_f_ff & ~scl_prev_ff;
	wire      scl_fall = ~scl_f_ff & scl_prev_ff;
	wire      start_ev = scl_f_ff & scl_prev_ff & sda_prev_ff & ~sda_f_ff;
	wire      stop_ev  = scl_f_ff & scl_prev_ff & ~sda_prev_ff & sda_f_ff;

	// A level only counts once the second and third stages agree, which masks glitches.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			scl_sync_ff   <= 3'h7;
			sda_sync_ff   <= 3'h7;
			scl_f_ff      <= 1'b1;
			sda_f_ff      <= 1'b1;
			scl_prev_ff   <= 1'b1;
			sda_prev_ff   <= 1'b1;
			strap_done_ff <= 1'b0;
			own_addr_ff   <= `TGT_ADDR_0;
			bus_busy_ff   <= 1'b0;
		end else begin
			scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
			sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
			if (scl_sync_ff[1] == scl_sync_ff[2])
				scl_f_ff <= scl_sync_ff[2];
			if (sda_sync_ff[1] == sda_sync_ff[2])
				sda_f_ff <= sda_sync_ff[2];
			scl_prev_ff <= scl_f_ff;
			sda_prev_ff <= sda_f_ff;
			// The strap is static, so it is caught once in the first cycle after release.
			if (!strap_done_ff) begin
				strap_done_ff <= 1'b1;
				own_addr_ff   <= strap_to_addr(address_strap_pin);
			end
			if (start_ev)
				bus_busy_ff <= 1'b1;
			else if (stop_ev)
				bus_busy_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// Register store and access arbitration.
	// ****************************************************************
	reg  [7:0] cfg_mem [0:`MEM_DEPTH-1];
	reg        loc_pend_ff;
	reg        loc_we_ff;
	reg  [7:0] t_offset_ff;
	reg  [7:0] t_shift_ff;
	wire       grant_local = loc_pend_ff & ~remote_req;

	// Remote takes the port first; a waiting local access stretches SCL instead.
	always @(posedge ref_clk) begin
		if (remote_req && remote_we)
			cfg_mem[remote_addr] <= remote_wdata;
		else if (grant_local && loc_we_ff)
			cfg_mem[t_offset_ff] <= t_shift_ff;
	end

	// Remote answers one cycle after its request.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			remote_ack_ff   <= 1'b0;
			remote_rdata_ff <= 8'h00;
		end else begin
			remote_ack_ff <= remote_req;
			if (remote_req && !remote_we)
				remote_rdata_ff <= cfg_mem[remote_addr];
		end
	end

	// ****************************************************************
	// Target state machine.
	// ****************************************************************
	reg [2:0] t_state_ff;
	reg [3:0] t_bits_ff;
	reg       t_have_off_ff;
	reg       t_more_ff;
	reg       t_drive_ff;

	// Bits are taken on SCL rise and driven after SCL fall.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			t_state_ff    <= T_IDLE;
			t_bits_ff     <= 4'h0;
			t_shift_ff    <= 8'h00;
			t_offset_ff   <= 8'h00;
			t_have_off_ff <= 1'b0;
			t_more_ff     <= 1'b0;
			t_drive_ff    <= 1'b0;
			loc_pend_ff   <= 1'b0;
			loc_we_ff     <= 1'b0;
		end else if (start_ev) begin
			t_state_ff    <= T_ADDR;
			t_bits_ff     <= 4'h0;
			t_have_off_ff <= 1'b0;
			t_drive_ff    <= 1'b0;
			loc_pend_ff   <= 1'b0;
		end else if (stop_ev) begin
			t_state_ff  <= T_IDLE;
			t_drive_ff  <= 1'b0;
			loc_pend_ff <= 1'b0;
		end else begin
			if (grant_local) begin
				loc_pend_ff <= 1'b0;
				t_offset_ff <= t_offset_ff + 8'h01;
				if (!loc_we_ff) begin
					t_shift_ff <= cfg_mem[t_offset_ff];
					t_drive_ff <= ~cfg_mem[t_offset_ff][7];
				end
			end
			case (t_state_ff)
				T_ADDR, T_WR: begin
					if (scl_rise) begin
						t_shift_ff <= {t_shift_ff[6:0], sda_f_ff};
						t_bits_ff  <= t_bits_ff + 4'h1;
					end else if (scl_fall && t_bits_ff == 4'h8) begin
						if (t_state_ff == T_ADDR) begin
							if (t_shift_ff[7:1] == own_addr_ff) begin
								t_drive_ff <= 1'b1;
								t_more_ff  <= t_shift_ff[0];
								t_state_ff <= T_AACK;
							end else begin
								t_state_ff <= T_IDLE;
							end
						end else begin
							t_drive_ff <= 1'b1;
							t_state_ff <= T_WACK;
							if (!t_have_off_ff) begin
								t_offset_ff   <= t_shift_ff;
								t_have_off_ff <= 1'b1;
							end else begin
								loc_pend_ff <= 1'b1;
								loc_we_ff   <= 1'b1;
							end
						end
					end
				end
				T_AACK, T_WACK: begin
					if (scl_fall) begin
						t_drive_ff <= 1'b0;
						t_bits_ff  <= 4'h0;
						if (t_state_ff == T_AACK && t_more_ff) begin
							loc_pend_ff <= 1'b1;
							loc_we_ff   <= 1'b0;
							t_state_ff  <= T_RD;
						end else begin
							t_state_ff <= T_WR;
						end
					end
				end
				T_RD: begin
					if (scl_fall) begin
						t_shift_ff <= {t_shift_ff[6:0], 1'b0};
						t_bits_ff  <= t_bits_ff + 4'h1;
						if (t_bits_ff == 4'h7) begin
							t_drive_ff <= 1'b0;
							t_state_ff <= T_RACK;
						end else begin
							t_drive_ff <= ~t_shift_ff[6];
						end
					end
				end
				T_RACK: begin
					if (scl_rise) begin
						t_more_ff <= ~sda_f_ff;
					end else if (scl_fall) begin
						t_bits_ff <= 4'h0;
						if (t_more_ff) begin
							loc_pend_ff <= 1'b1;
							loc_we_ff   <= 1'b0;
							t_state_ff  <= T_RD;
						end else begin
							t_state_ff <= T_IDLE;
						end
					end
				end
				default: t_state_ff <= T_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Proxy master forwarding writes from the control link.
	// ****************************************************************
	reg [2:0]  m_state_ff;
	reg [1:0]  m_ph_ff;
	reg [15:0] m_timer_ff;
	reg [4:0]  m_bit_ff;
	reg [`PX_FRAME_BITS-1:0] m_frame_ff;
	reg        m_sda_low_ff;
	reg        m_scl_low_ff;
	wire       m_tick   = (m_timer_ff == 16'h0000);
	wire       m_ackbit = (m_bit_ff == `PX_ACK_BIT_0) || (m_bit_ff == `PX_ACK_BIT_1) ||
	                      (m_bit_ff == `PX_ACK_BIT_2);

	// Each bit is four quarter periods; the high quarter waits while a target stretches.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			m_state_ff   <= M_IDLE;
			m_ph_ff      <= 2'h0;
			m_timer_ff   <= 16'h0000;
			m_bit_ff     <= 5'h00;
			m_frame_ff   <= {`PX_FRAME_BITS{1'b1}};
			m_sda_low_ff <= 1'b0;
			m_scl_low_ff <= 1'b0;
			px_busy_ff   <= 1'b0;
			px_done_ff   <= 1'b0;
			px_lost_ff   <= 1'b0;
		end else begin
			px_done_ff <= 1'b0;
			px_lost_ff <= 1'b0;
			if (!m_tick && !(m_ph_ff == 2'h2 && !scl_f_ff))
				m_timer_ff <= m_timer_ff - 16'h0001;
			case (m_state_ff)
				M_IDLE: begin
					if (px_req) begin
						m_frame_ff <= {px_target, 1'b0, 1'b1, px_offset, 1'b1, px_data, 1'b1};
						px_busy_ff <= 1'b1;
						m_state_ff <= M_WAIT;
					end
				end
				M_WAIT: begin
					if (!bus_busy_ff) begin
						m_state_ff <= M_START;
						m_ph_ff    <= 2'h0;
						m_timer_ff <= SCL_QUARTER;
					end
				end
				M_START: begin
					m_sda_low_ff <= 1'b1;
					if (m_tick) begin
						m_scl_low_ff <= 1'b1;
						m_bit_ff     <= 5'h00;
						m_state_ff   <= M_BITS;
						m_timer_ff   <= SCL_QUARTER;
					end
				end
				M_BITS: begin
					if (m_tick) begin
						m_timer_ff <= SCL_QUARTER;
						m_ph_ff    <= m_ph_ff + 2'h1;
						case (m_ph_ff)
							2'h0: m_sda_low_ff <= ~m_frame_ff[`PX_FRAME_BITS-1-m_bit_ff];
							2'h1: m_scl_low_ff <= 1'b0;
							2'h2: begin
								if (!m_sda_low_ff && !sda_f_ff && !m_ackbit) begin
									m_sda_low_ff <= 1'b0;
									m_scl_low_ff <= 1'b0;
									px_lost_ff   <= 1'b1;
									m_ph_ff      <= 2'h0;
									m_state_ff   <= M_WAIT;
								end
							end
							default: begin
								m_scl_low_ff <= 1'b1;
								m_bit_ff     <= m_bit_ff + 5'h01;
								if (m_bit_ff == `PX_ACK_BIT_2) begin
									m_state_ff <= M_STOP;
									m_ph_ff    <= 2'h0;
								end
							end
						endcase
					end
				end
				M_STOP: begin
					if (m_tick) begin
						m_timer_ff <= SCL_QUARTER;
						m_ph_ff    <= m_ph_ff + 2'h1;
						case (m_ph_ff)
							2'h0: m_sda_low_ff <= 1'b1;
							2'h1: m_scl_low_ff <= 1'b0;
							default: begin
								m_sda_low_ff <= 1'b0;
								px_busy_ff   <= 1'b0;
								px_done_ff   <= 1'b1;
								m_ph_ff      <= 2'h0;
								m_state_ff   <= M_IDLE;
							end
						endcase
					end
				end
				default: m_state_ff <= M_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Pin drivers.
	// ****************************************************************
	// Both lines are open drain: the output level is always low, the enable decides.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			scl_out_ff  <= 1'b0;
			sda_out_ff  <= 1'b0;
			scl_oe_n_ff <= 1'b1;
			sda_oe_n_ff <= 1'b1;
		end else begin
			scl_out_ff  <= 1'b0;
			sda_out_ff  <= 1'b0;
			scl_oe_n_ff <= ~((loc_pend_ff & ~scl_f_ff) | m_scl_low_ff);
			sda_oe_n_ff <= ~(t_drive_ff | m_sda_low_ff);
		end
	end

endmodule

// File: rtl/serial_control_i2c_target_regs.vh
`ifndef SERIAL_CONTROL_I2C_TARGET_REGS_VH
`define SERIAL_CONTROL_I2C_TARGET_REGS_VH

// ****************************************************************
// Target addresses selected by the address strap level.
// ****************************************************************
`define TGT_ADDR_0 7'h0C
`define TGT_ADDR_1 7'h0E
`define TGT_ADDR_2 7'h10
`define TGT_ADDR_3 7'h12
`define TGT_ADDR_4 7'h14
`define TGT_ADDR_5 7'h16
`define TGT_ADDR_6 7'h18
`define TGT_ADDR_7 7'h1A

// ****************************************************************
// Timing of the proxy master.
// ****************************************************************
`define REF_CLK_MHZ     100
`define SCL_QUARTER_NS  2500
`define SCL_QUARTER_CYC ((`SCL_QUARTER_NS * `REF_CLK_MHZ) / 1000)

// ****************************************************************
// Frame layout of a proxy write: address, ack, offset, ack, data, ack.
// ****************************************************************
`define PX_FRAME_BITS 27
`define PX_ACK_BIT_0  5'h08
`define PX_ACK_BIT_1  5'h11
`define PX_ACK_BIT_2  5'h1A
`define MEM_DEPTH     256

`endif

// File: verification/serial_control_i2c_target_sva.sv
`timescale 1ns/1ps
// ********************************************
// Port checker for the serial control target.
// ********************************************
module serial_control_i2c_target_sva (
	input logic       ref_clk,
	input logic       reset,
	input logic [2:0] address_strap_pin,
	input logic [6:0] own_addr_ff,
	input logic       sda_oe_n_ff,
	input logic       remote_req,
	input logic       remote_we,
	input logic [7:0] remote_addr,
	input logic [7:0] remote_wdata,
	input logic       remote_ack_ff,
	input logic [7:0] remote_rdata_ff,
	input logic       px_busy_ff,
	input logic       px_done_ff,
	input logic       px_lost_ff
);
	logic [1:0] settle_ff;

	// Edges since release; the address is judged only once it has had time to load.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			settle_ff <= 2'h0;
		end else if (settle_ff != 2'h3) begin
			settle_ff <= settle_ff + 2'h1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// Each assertion but done_pulse_a and addr_map_a ties an output to its cause with the exact cycle count; done_pulse_a limits the done pulse to one cycle.
	addr_map_a: assert property (
		settle_ff == 2'h3 |-> own_addr_ff == 7'h0C + {3'h0, address_strap_pin, 1'b0})
		else $error("Own address does not follow the strap.");
	remote_ack_a: assert property (
		remote_req |=> remote_ack_ff)
		else $error("Remote access not answered in one cycle.");
	ack_cause_a: assert property (
		remote_ack_ff |-> $past(remote_req))
		else $error("Remote answer without a request.");
	remote_rw_a: assert property (
		remote_req && remote_we ##1 remote_req && !remote_we && remote_addr == $past(remote_addr)
		|=> remote_rdata_ff == $past(remote_wdata, 2))
		else $error("Remote read does not return the byte just written.");
	done_pulse_a: assert property (
		px_done_ff |=> !px_done_ff)
		else $error("Proxy done longer than one cycle.");
	done_busy_a: assert property (
		px_done_ff |-> $past(px_busy_ff))
		else $error("Proxy done without a transfer in flight.");
	lost_release_a: assert property (
		px_lost_ff |-> sda_oe_n_ff [*4])
		else $error("Data line still driven after a lost arbitration.");
	lost_retry_a: assert property (
		px_lost_ff |-> px_busy_ff && !px_done_ff)
		else $error("Proxy gave up instead of retrying.");
endmodule

bind serial_control_i2c_target serial_control_i2c_target_sva u_sva (.*);

// File: verification/i2c_host_model.sv
`timescale 1ns/1ps
// ********************************************
// Host controller on the serial control bus.
// ********************************************
module i2c_host_model (
	input  wire ref_clk,
	input  wire scl_w,
	input  wire sda_w,
	output reg  scl_oe_n_ff,
	output reg  sda_oe_n_ff
);
	integer stall_cnt;

	// Both lines start released, so the pull-ups leave the bus idle.
	initial begin
		scl_oe_n_ff = 1'b1;
		sda_oe_n_ff = 1'b1;
		stall_cnt = 0;
	end

	// Release the clock and wait, bounded, while a target stretches it.
	task automatic rise_scl;
		integer i;
		scl_oe_n_ff <= 1'b1;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (!scl_w && i < 400);
		if (!scl_w) stall_cnt++;
	endtask

	// The low phase is long enough for the target's late release of an acknowledge.
	task automatic bit_io(input logic b, output logic s);
		repeat (2) @(posedge ref_clk);
		sda_oe_n_ff <= b;
		repeat (5) @(posedge ref_clk);
		rise_scl();
		repeat (3) @(posedge ref_clk);
		s = sda_w;
		scl_oe_n_ff <= 1'b0;
	endtask

	// Eight bits most significant first, then the acknowledge slot.
	task automatic byte_io(input [7:0] d, input logic ack_in, output [7:0] r, output logic a);
		integer i;
		logic s;
		for (i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
			r[i] = s;
		end
		bit_io(ack_in, a);
	endtask

	// Start or repeated start: the data line falls while the clock is high.
	task automatic start;
		repeat (2) @(posedge ref_clk);
		sda_oe_n_ff <= 1'b1;
		repeat (5) @(posedge ref_clk);
		rise_scl();
		repeat (3) @(posedge ref_clk);
		sda_oe_n_ff <= 1'b0;
		repeat (4) @(posedge ref_clk);
		scl_oe_n_ff <= 1'b0;
	endtask

	// Stop: the data line rises while the clock is high.
	task automatic stop;
		repeat (2) @(posedge ref_clk);
		sda_oe_n_ff <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rise_scl();
		repeat (3) @(posedge ref_clk);
		sda_oe_n_ff <= 1'b1;
		repeat (8) @(posedge ref_clk);
	endtask

	// Holds the data line low to contend with another master; a zero always wins.
	task automatic pull_sda;
		@(posedge ref_clk);
		sda_oe_n_ff <= 1'b0;
	endtask
endmodule

// File: verification/serial_control_i2c_target_tb.sv
`timescale 1ns/1ps
// ********************************************
// Self-checking bench for the serial control target.
// ********************************************
module serial_control_i2c_target_tb;
	logic       ref_clk;
	logic       reset = 1'b1;
	logic [2:0] address_strap_pin = 3'h0;
	logic       remote_req = 1'b0;
	logic       remote_we = 1'b0;
	logic [7:0] remote_addr = 8'h00;
	logic [7:0] remote_wdata = 8'h00;
	logic       px_req = 1'b0;
	logic [6:0] px_target = 7'h0C;
	logic [7:0] px_offset = 8'h10;
	logic [7:0] px_data = 8'h55;
	wire        scl_out_ff, scl_oe_n_ff, sda_out_ff, sda_oe_n_ff, h_scl_n, h_sda_n;
	wire        remote_ack_ff, px_busy_ff, px_done_ff, px_lost_ff;
	wire  [6:0] own_addr_ff;
	wire  [7:0] remote_rdata_ff;
	integer     bad_count = 0;
	integer     checked = 0;

	// Open-drain wires: low when any party pulls, pulled up otherwise.
	wire scl_in = (scl_oe_n_ff | scl_out_ff) & h_scl_n;
	wire sda_in = (sda_oe_n_ff | sda_out_ff) & h_sda_n;

	serial_control_i2c_target #(.SCL_QUARTER(16'h0008)) dut (.*);
	i2c_host_model host (.ref_clk, .scl_w(scl_in), .sda_w(sda_in), .scl_oe_n_ff(h_scl_n),
		.sda_oe_n_ff(h_sda_n));

	// Free-running 100 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wr_byte(input [7:0] d, input logic exp_ack);
		logic [7:0] r;
		logic a;
		host.byte_io(d, 1'b1, r, a);
		chk("acknowledge", {7'h00, exp_ack}, {7'h00, a});
	endtask

	task automatic rd_byte(input logic last, input [7:0] exp);
		logic [7:0] r;
		logic a;
		host.byte_io(8'hFF, last, r, a);
		chk("read byte", exp, r);
	endtask

	// Proxy flags are one-cycle pulses, so each edge is inspected; the wait is bounded.
	task automatic wait_px(input logic lost);
		integer i;
		for (i = 0; i < 5000; i++) begin
			@(posedge ref_clk);
			#1;
			if (lost ? px_lost_ff : px_done_ff) return;
		end
		chk("proxy flag", 8'h01, 8'h00);
		end_sim();
	endtask

	// Each strap level is applied under reset and its address read back.
	task automatic t_strap;
		integer l;
		for (l = 0; l < 8; l++) begin
			@(posedge ref_clk);
			reset <= 1'b1;
			address_strap_pin <= l[2:0];
			repeat (5) @(posedge ref_clk);
			reset <= 1'b0;
			repeat (6) @(posedge ref_clk);
			#1;
			chk("own address", 8'h0C + 8'(2 * l), {1'b0, own_addr_ff});
		end
	endtask

	// Back-to-back remote write and read of one offset.
	task automatic t_remote;
		@(posedge ref_clk);
		remote_req <= 1'b1;
		remote_we <= 1'b1;
		remote_addr <= 8'h42;
		remote_wdata <= 8'h5A;
		@(posedge ref_clk);
		remote_we <= 1'b0;
		@(posedge ref_clk);
		remote_req <= 1'b0;
		#1;
		chk("remote data", 8'h5A, remote_rdata_ff);
		chk("remote ack", 8'h01, {7'h00, remote_ack_ff});
	endtask

	// Write two bytes, then read three across a repeated start, the last one from the link.
	// Remote reads every other cycle during the write, so local stores must wait and stretch.
	task automatic t_write_read;
		logic host_busy;
		host_busy = 1'b1;
		fork
			begin
				host.start();
				wr_byte(8'h34, 1'b0);
				wr_byte(8'h40, 1'b0);
				wr_byte(8'hA5, 1'b0);
				wr_byte(8'h3C, 1'b0);
				host.stop();
				host_busy = 1'b0;
			end
			while (host_busy) begin
				@(posedge ref_clk);
				remote_req <= 1'b1;
				remote_addr <= 8'h42;
				@(posedge ref_clk);
				remote_req <= 1'b0;
				#1;
				chk("remote during local", 8'h5A, remote_rdata_ff);
			end
		join
		host.start();
		wr_byte(8'h34, 1'b0);
		wr_byte(8'h40, 1'b0);
		host.start();
		wr_byte(8'h35, 1'b0);
		rd_byte(1'b0, 8'hA5);
		rd_byte(1'b0, 8'h3C);
		rd_byte(1'b1, 8'h5A);
		host.stop();
		@(posedge ref_clk);
		remote_req <= 1'b1;
		remote_addr <= 8'h41;
		@(posedge ref_clk);
		remote_req <= 1'b0;
		#1;
		chk("remote data", 8'h3C, remote_rdata_ff);
	endtask

	// A foreign address must be left unanswered.
	task automatic t_nack;
		host.start();
		wr_byte(8'h18, 1'b1);
		host.stop();
	endtask

	// A clean proxy write, then one where the host wins the data line.
	// The remote port stays quiet while the proxy forwards, so one direction runs at a time.
	task automatic t_proxy;
		integer i;
		@(posedge ref_clk);
		px_req <= 1'b1;
		@(posedge ref_clk);
		px_req <= 1'b0;
		#1;
		chk("proxy busy", 8'h01, {7'h00, px_busy_ff});
		wait_px(1'b0);
		@(posedge ref_clk);
		px_req <= 1'b1;
		@(posedge ref_clk);
		px_req <= 1'b0;
		for (i = 0; i < 2000 && sda_in; i++) @(posedge ref_clk);
		chk("proxy start", 8'h00, {7'h00, sda_in});
		host.pull_sda();
		wait_px(1'b1);
		host.stop();
		wait_px(1'b0);
		#1;
		chk("proxy busy", 8'h00, {7'h00, px_busy_ff});
	endtask

	// Main sequence: reset, scenarios, verdict.
	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		t_strap();
		t_remote();
		t_write_read();
		t_nack();
		t_proxy();
		chk("clock stalls", 8'h00, host.stall_cnt[7:0]);
		chk("pin levels", 8'h00, {6'h00, scl_out_ff, sda_out_ff});
		end_sim();
	end
endmodule
